// ==== pkg/tpp_consts.vh ====
// Constants for the two-phase peak current PWM timing block
`ifndef TPP_CONSTS_VH
`define TPP_CONSTS_VH
// ============================================================
// Clock and timing
`define TPP_CLK_MHZ          100
`define TPP_TICKS_PER_PERIOD 12
`define TPP_LAST_TICK        4'hb
`define TPP_HALF_TICKS       6
`define TPP_DEG_PER_TICK     30
`define TPP_NS_TO_CYC(ns)    ((((ns) * `TPP_CLK_MHZ) + 999) / 1000)
// ============================================================
// Three-level select codes
`define TPP_SEL_GND  2'h0
`define TPP_SEL_OPEN 2'h1
`define TPP_SEL_SUP  2'h2
// ============================================================
// Duty limits in percent, blanking in ns
`define TPP_DUTY_LIMIT_SELECT_GND_PCT  96
`define TPP_DUTY_LIMIT_SELECT_OPEN_PCT 84
`define TPP_DUTY_LIMIT_SELECT_SUP_PCT  75
`define TPP_BLANK_GND_NS  210
`define TPP_BLANK_OPEN_NS 290
`define TPP_BLANK_SUP_NS  375
// ============================================================
// Phase offsets in degrees
`define TPP_PH_GND_DEG   180
`define TPP_PH_OPEN_DEG  180
`define TPP_PH_SUP_DEG   120
`define TPP_CK_GND_DEG   90
`define TPP_CK_OPEN_DEG  60
`define TPP_CK_SUP_DEG   240
// ============================================================
// Ramp gain, scaled by 200
`define TPP_GAIN_GND  9'h07d
`define TPP_GAIN_OPEN 9'h0c8
`define TPP_GAIN_SUP  9'h14c
// ============================================================
// Reference clock range
`define TPP_SYNC_MIN_KHZ 50
`define TPP_SYNC_MAX_KHZ 650
`define TPP_SYNC_MAX_PER ((`TPP_CLK_MHZ * 1000) / `TPP_SYNC_MIN_KHZ)
`define TPP_SYNC_MIN_PER (((`TPP_CLK_MHZ * 1000) + `TPP_SYNC_MAX_KHZ - 1) / `TPP_SYNC_MAX_KHZ)
// ============================================================
// Register map and fields
`define TPP_ADDR_CONFIG 12'h000
`define TPP_ADDR_TICK   12'h004
`define TPP_ADDR_STATUS 12'h008
`define TPP_CFG_DUTY    1:0
`define TPP_CFG_BLANK   3:2
`define TPP_CFG_PHASE   5:4
`define TPP_CFG_SLOPE   7:6
`define TPP_CFG_SYNC    8
`define TPP_CFG_RST     9'h055
`define TPP_TICK_RST    16'h001c
// ============================================================
// Sized copies used by the logic, so every assignment is width exact
`define TPP_DUTY_GND    7'h60
`define TPP_DUTY_OPEN   7'h54
`define TPP_DUTY_SUP    7'h4b
`define TPP_MINC_GND    8'h15
`define TPP_MINC_OPEN   8'h1d
`define TPP_MINC_SUP    8'h26
`define TPP_PHT_GND     4'h6
`define TPP_PHT_OPEN    4'h6
`define TPP_PHT_SUP     4'h4
`define TPP_CKT_GND     4'h3
`define TPP_CKT_OPEN    4'h2
`define TPP_CKT_SUP     4'h8
`define TPP_TICKS_4     4'hc
`define TPP_TICKS_16    16'h000c
`define TPP_TICKS_20    20'h0000c
`define TPP_HALF_4      4'h6
`define TPP_SYNC_MIN_16 16'h009a
`define TPP_SYNC_MAX_16 16'h07d0
`define TPP_PCT_DIV     27'h0000064
`endif

// ==== verilog/tpp_tick.v ====
// Twelve-times switching clock: tick index and tick start pulse
`timescale 1ns/100ps
`include "tpp_consts.vh"
module tpp_tick (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        run,
  input  wire        restart,
  input  wire [15:0] tick_len,
  output reg  [3:0]  tick_idx_r,
  output reg         tick_start_r
);
  reg [15:0] sub_r;

  // ============================================================
  // Counter, restarted to tick zero on alignment
  always @(posedge clock)
  begin
    if (!rst_b || !run)
    begin
      sub_r        <= 16'h0000;
      tick_idx_r   <= 4'h0;
      tick_start_r <= 1'b0;
    end
    else if (restart)
    begin
      sub_r        <= 16'h0000;
      tick_idx_r   <= 4'h0;
      tick_start_r <= 1'b1;
    end
    else if (sub_r + 16'h0001 >= tick_len)
    begin
      sub_r        <= 16'h0000;
      tick_idx_r   <= (tick_idx_r == `TPP_LAST_TICK) ? 4'h0 : tick_idx_r + 4'h1;
      tick_start_r <= 1'b1;
    end
    else
    begin
      sub_r        <= sub_r + 16'h0001;
      tick_start_r <= 1'b0;
    end
  end
endmodule // tpp_tick

// ==== verilog/tpp_chan.v ====
// One channel PWM latch with blanking and duty limit
`timescale 1ns/100ps
module tpp_chan (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        run,
  input  wire        set_pulse,
  input  wire        trip,
  input  wire [7:0]  min_cyc,
  input  wire [19:0] max_cyc,
  output reg         drive_r
);
  reg [19:0] on_cnt_r;

  // ============================================================
  // Latch: set by the channel clock, reset by trip or limit
  always @(posedge clock)
  begin
    if (!rst_b || !run)
    begin
      drive_r  <= 1'b0;
      on_cnt_r <= 20'h00000;
    end
    else if (set_pulse)
    begin
      drive_r  <= 1'b1;
      on_cnt_r <= 20'h00001;
    end
    else if (drive_r)
    begin
      on_cnt_r <= on_cnt_r + 20'h00001;
      // Trip inside the blanking window is masked
      if (trip && on_cnt_r >= {12'h000, min_cyc})
        drive_r <= 1'b0;
      else if (on_cnt_r >= max_cyc)
        drive_r <= 1'b0;
    end
    // Once released only the next set pulse reopens it
  end
endmodule // tpp_chan

// ==== verilog/tpp_pwm.v ====
// Two-phase peak current mode PWM timing with APB registers
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "tpp_consts.vh"

module tpp_pwm (
  input  wire        clock,
  input  wire        rst_b,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        run_above_thresh,
  input  wire        sync_in,
  input  wire        peak_current_trip1,
  input  wire        peak_current_trip2,
  output wire        first_switch_drive,
  output wire        second_switch_drive,
  output reg         chain_clock_out,
  output reg  [8:0]  ramp_gain_code
);

  // ============================================================
  // Declarations
  reg  [8:0]  cfg_r;
  reg  [15:0] tick_len_r;
  reg  [6:0]  duty_pct_r;
  reg  [7:0]  min_cyc_r;
  reg  [3:0]  ph_ticks_r;
  reg  [3:0]  ck_ticks_r;
  reg  [19:0] max_cyc_r;
  reg         run_q_r;
  reg         sync_q_r;
  reg  [15:0] per_cnt_r;
  reg  [15:0] meas_r;
  reg         locked_r;
  reg         range_err_r;
  reg  [3:0]  ck_rel_nxt;
  reg  [31:0] rd_nxt;
  reg         mapped_nxt;
  wire        setup_ph;
  wire        access_ph;
  wire        run_rise;
  wire        sync_rise;
  wire        restart;
  wire [15:0] tick_len_use;
  wire [19:0] period_cyc;
  wire [26:0] duty_prod;
  wire [26:0] duty_quot;
  wire [3:0]  tick_idx;
  wire        tick_start;
  wire [1:0]  trip_vec;
  wire [1:0]  drive_vec;
  wire [7:0]  ch_off;

  // ============================================================
  // APB slave: one wait state, answer in the second access cycle
  assign setup_ph  = psel && penable && !pready;
  assign access_ph = psel && penable && pready;

  always @*
  begin
    rd_nxt     = 32'h00000000;
    mapped_nxt = 1'b1;
    case (paddr)
      `TPP_ADDR_CONFIG:
      begin
        rd_nxt[8:0] = cfg_r;
      end
      `TPP_ADDR_TICK:
      begin
        rd_nxt[15:0] = tick_len_r;
      end
      `TPP_ADDR_STATUS:
      begin
        rd_nxt[0]    = drive_vec[0];
        rd_nxt[1]    = drive_vec[1];
        rd_nxt[2]    = run_q_r;
        rd_nxt[3]    = locked_r;
        rd_nxt[4]    = range_err_r;
        rd_nxt[11:8] = tick_idx;
      end
      default:
      begin
        mapped_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !mapped_nxt;
      if (setup_ph && !pwrite)
        prdata <= rd_nxt;
    end
  end

  // ============================================================
  // Configuration registers
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      cfg_r      <= `TPP_CFG_RST;
      tick_len_r <= `TPP_TICK_RST;
    end
    else if (access_ph && pwrite)
    begin
      if (paddr == `TPP_ADDR_CONFIG)
        cfg_r <= pwdata[8:0];
      // Zero length is floored to one, which the tick counter runs the same way
      if (paddr == `TPP_ADDR_TICK)
        tick_len_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    end
  end

  // ============================================================
  // Three-level select decode
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      duty_pct_r     <= `TPP_DUTY_OPEN;
      min_cyc_r      <= `TPP_MINC_OPEN;
      ph_ticks_r     <= `TPP_PHT_OPEN;
      ck_ticks_r     <= `TPP_CKT_OPEN;
      ramp_gain_code <= `TPP_GAIN_OPEN;
    end
    else
    begin
      case (cfg_r[`TPP_CFG_DUTY])
        `TPP_SEL_GND: duty_pct_r <= `TPP_DUTY_GND;
        `TPP_SEL_SUP: duty_pct_r <= `TPP_DUTY_SUP;
        default:      duty_pct_r <= `TPP_DUTY_OPEN;
      endcase
      case (cfg_r[`TPP_CFG_BLANK])
        `TPP_SEL_GND: min_cyc_r <= `TPP_MINC_GND;
        `TPP_SEL_SUP: min_cyc_r <= `TPP_MINC_SUP;
        default:      min_cyc_r <= `TPP_MINC_OPEN;
      endcase
      case (cfg_r[`TPP_CFG_PHASE])
        `TPP_SEL_GND:
        begin
          ph_ticks_r <= `TPP_PHT_GND;
          ck_ticks_r <= `TPP_CKT_GND;
        end
        `TPP_SEL_SUP:
        begin
          ph_ticks_r <= `TPP_PHT_SUP;
          ck_ticks_r <= `TPP_CKT_SUP;
        end
        default:
        begin
          ph_ticks_r <= `TPP_PHT_OPEN;
          ck_ticks_r <= `TPP_CKT_OPEN;
        end
      endcase
      case (cfg_r[`TPP_CFG_SLOPE])
        `TPP_SEL_GND: ramp_gain_code <= `TPP_GAIN_GND;
        `TPP_SEL_SUP: ramp_gain_code <= `TPP_GAIN_SUP;
        default:      ramp_gain_code <= `TPP_GAIN_OPEN;
      endcase
    end
  end

  // ============================================================
  // Duty limit in clock cycles, the duty fraction of twelve ticks rounded down
  assign period_cyc = {4'h0, tick_len_use} * `TPP_TICKS_20;
  assign duty_prod  = {7'h00, period_cyc} * {20'h00000, duty_pct_r};
  // Quotient stays below 2^20 for any 16-bit tick length, so the cut is safe
  assign duty_quot  = duty_prod / `TPP_PCT_DIV;

  always @(posedge clock)
  begin
    if (!rst_b)
      max_cyc_r <= 20'h00000;
    else
      max_cyc_r <= duty_quot[19:0];
  end

  // ============================================================
  // Reference clock measurement and lock
  // Lock needs one in-range period; a stopped reference drops it
  assign run_rise  = run_above_thresh && !run_q_r;
  assign sync_rise = sync_in && !sync_q_r;

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      run_q_r     <= 1'b0;
      sync_q_r    <= 1'b0;
      per_cnt_r   <= 16'h0000;
      meas_r      <= `TPP_TICK_RST;
      locked_r    <= 1'b0;
      range_err_r <= 1'b0;
    end
    else
    begin
      run_q_r  <= run_above_thresh;
      sync_q_r <= sync_in;
      if (!cfg_r[`TPP_CFG_SYNC])
      begin
        per_cnt_r   <= 16'h0000;
        locked_r    <= 1'b0;
        range_err_r <= 1'b0;
      end
      else if (sync_rise)
      begin
        per_cnt_r <= 16'h0000;
        if (per_cnt_r + 16'h0001 >= `TPP_SYNC_MIN_16 &&
            per_cnt_r + 16'h0001 <= `TPP_SYNC_MAX_16)
        begin
          meas_r      <= per_cnt_r + 16'h0001;
          locked_r    <= 1'b1;
          range_err_r <= 1'b0;
        end
        else
        begin
          locked_r    <= 1'b0;
          range_err_r <= 1'b1;
        end
      end
      else if (per_cnt_r >= `TPP_SYNC_MAX_16)
      begin
        locked_r    <= 1'b0;
        range_err_r <= 1'b1;
      end
      else
        per_cnt_r <= per_cnt_r + 16'h0001;
    end
  end

  assign tick_len_use = locked_r ? (meas_r / `TPP_TICKS_16) : tick_len_r;

  // Reference edge restarts the period once locked, so the first drive follows it
  assign restart = run_rise || (locked_r && sync_rise);

  // ============================================================
  // Twelve-times clock
  tpp_tick u_tick (
    .clock        (clock),
    .rst_b        (rst_b),
    .run          (run_above_thresh),
    .restart      (restart),
    .tick_len     (tick_len_use),
    .tick_idx_r   (tick_idx),
    .tick_start_r (tick_start)
  );

  // ============================================================
  // Channels
  assign trip_vec = {peak_current_trip2, peak_current_trip1};
  assign ch_off   = {ph_ticks_r, 4'h0};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_chan
      tpp_chan u_chan (
        .clock     (clock),
        .rst_b     (rst_b),
        .run       (run_above_thresh),
        .set_pulse (tick_start && (tick_idx == ch_off[gi*4 +: 4])),
        .trip      (trip_vec[gi]),
        .min_cyc   (min_cyc_r),
        .max_cyc   (max_cyc_r),
        .drive_r   (drive_vec[gi])
      );
    end
  endgenerate

  assign first_switch_drive  = drive_vec[0];
  assign second_switch_drive = drive_vec[1];

  // ============================================================
  // Chained clock: half-period high, starting at its offset tick
  always @*
  begin
    if (tick_idx >= ck_ticks_r)
      ck_rel_nxt = tick_idx - ck_ticks_r;
    else
      ck_rel_nxt = tick_idx + `TPP_TICKS_4 - ck_ticks_r;
  end

  always @(posedge clock)
  begin
    if (!rst_b)
      chain_clock_out <= 1'b0;
    else
      chain_clock_out <= run_above_thresh && (ck_rel_nxt < `TPP_HALF_4);
  end

endmodule // tpp_pwm

// ==== tb/tpp_pwm_properties.sv ====
// Concurrent checks on the ports of the two-phase PWM timing block
`timescale 1ns/100ps
module tpp_pwm_checker (
  input wire        clock,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        run_above_thresh,
  input wire        sync_in,
  input wire        peak_current_trip1,
  input wire        first_switch_drive,
  input wire        second_switch_drive,
  input wire        chain_clock_out
);
  // ==========
  // Shadow of the select fields, on-time and spacing counters
  // Figures assume the reset tick length of 28 cycles
  reg  [8:0] cfg_r;
  reg  [9:0] on_r;
  reg  [9:0] gap_r;
  reg  [9:0] run_r;
  wire [1:0] ph = cfg_r[5:4];
  wire [9:0] min_c = (cfg_r[3:2] == 2'h0) ? 10'h015 : (cfg_r[3:2] == 2'h2) ? 10'h026 : 10'h01d;
  wire [9:0] lim_c = (cfg_r[1:0] == 2'h0) ? 10'h142 : (cfg_r[1:0] == 2'h2) ? 10'h0fc : 10'h11a;
  wire       rise1 = first_switch_drive && (on_r == 10'h000) && !cfg_r[8];
  always @(posedge clock)
  begin
    if (!rst_b) cfg_r <= 9'h055;
    else if (psel && penable && pready && pwrite && paddr == 12'h000) cfg_r <= pwdata[8:0];
    on_r <= first_switch_drive ? on_r + 10'h001 : 10'h000;
    run_r <= !run_above_thresh ? 10'h000 : (run_r == 10'h3ff) ? run_r : run_r + 10'h001;
    // A reference edge may legally realign the period, so spacing restarts there
    if (!rst_b || !run_above_thresh || sync_in) gap_r <= 10'h3ff;
    else if (first_switch_drive && on_r == 10'h000) gap_r <= 10'h001;
    else if (gap_r != 10'h3ff) gap_r <= gap_r + 10'h001;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========
  // Properties
  property p_run_off; !run_above_thresh |=> !first_switch_drive && !second_switch_drive; endproperty
  a_run_off: assert property (p_run_off) else $error("drive high while run low");
  property p_min_on; $fell(first_switch_drive) && $past(run_above_thresh) |-> on_r >= min_c; endproperty
  a_min_on: assert property (p_min_on) else $error("pulse shorter than blanking");
  property p_max_on; first_switch_drive |-> on_r < lim_c; endproperty
  a_max_on: assert property (p_max_on) else $error("pulse past duty limit");
  property p_release;
    first_switch_drive && peak_current_trip1 && on_r >= min_c - 10'h001 |=> !first_switch_drive;
  endproperty
  a_release: assert property (p_release) else $error("trip did not release drive");
  property p_one; first_switch_drive && on_r == 10'h000 |-> gap_r >= 10'h150; endproperty
  a_one: assert property (p_one) else $error("two pulses in one period");
  property p_half; rise1 && ph != 2'h2 |-> ##168 ($rose(second_switch_drive) || run_r < 10'h0a8); endproperty
  a_half: assert property (p_half) else $error("second channel not half period later");
  property p_third; rise1 && ph == 2'h2 |-> ##112 ($rose(second_switch_drive) || run_r < 10'h070); endproperty
  a_third: assert property (p_third) else $error("second channel not third period later");
  property p_chain; rise1 && ph == 2'h1 |-> ##[55:57] ($rose(chain_clock_out) || run_r < 10'h037); endproperty
  a_chain: assert property (p_chain) else $error("chain clock offset wrong");
  c_trip: cover property (first_switch_drive && peak_current_trip1 && on_r >= min_c - 10'h001);
  c_limit: cover property (first_switch_drive && on_r == lim_c - 10'h001);
  c_sync: cover property ($rose(sync_in) && cfg_r[8]);
endmodule // tpp_pwm_checker

bind tpp_pwm tpp_pwm_checker chk_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .run_above_thresh, .sync_in, .peak_current_trip1, .first_switch_drive, .second_switch_drive, .chain_clock_out);

// ==== tb/tpp_switch_model.sv ====
// Behavioural power switch and current comparator for one channel
`timescale 1ns/100ps
module tpp_switch_model (
  input  wire       clock,
  input  wire       drive,
  input  wire [9:0] trip_after,
  output reg        trip
);
  // ==========
  // Inductor current ramp
  reg [9:0] on_r = 10'h000;
  initial trip = 1'b0;
  // Comparator sees no current while the switch is off
  always @(posedge clock)
  begin
    on_r <= drive ? on_r + 10'h001 : 10'h000;
    trip <= drive && (on_r >= trip_after);
  end
endmodule // tpp_switch_model

// ==== tb/test_two_phase_peak_current_pwm.sv ====
// Self-checking bench for the two-phase PWM timing block
`timescale 1ns/100ps
`include "tpp_consts.vh"
module test_two_phase_peak_current_pwm;
  // ==========
  // Signals
  reg         clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         run_above_thresh = 1'b0, sync_in = 1'b0, sync_on = 1'b0, err;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [9:0]  trip_after = 10'h3ff;
  wire [31:0] prdata;
  wire        pready, pslverr, peak_current_trip1, peak_current_trip2, d1, d2, ck;
  wire [8:0]  ramp_gain_code;
  integer     num_errors = 0, comparisons = 0, seed = 2, i, s, n, sc = 0, t2, tc, tf, w1;
  localparam  P = 12 * `TPP_TICK_RST;
  tpp_pwm dut_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .run_above_thresh, .sync_in, .peak_current_trip1, .peak_current_trip2, .first_switch_drive(d1),
    .second_switch_drive(d2), .chain_clock_out(ck), .ramp_gain_code);
  tpp_switch_model sw1_u (.clock, .drive(d1), .trip_after, .trip(peak_current_trip1));
  tpp_switch_model sw2_u (.clock, .drive(d2), .trip_after, .trip(peak_current_trip2));
  always #5 clock = ~clock;
  // Reference of 336 cycles, about 298 kHz, inside the lockable range
  always @(posedge clock)
  begin
    sc <= (!sync_on || sc == 167) ? 0 : sc + 1;
    sync_in <= sync_on && (sc == 167 ? !sync_in : sync_in);
  end
  // ==========
  // Helpers
  function integer pick(input integer s, input integer g, input integer o, input integer p);
    pick = (s == 0) ? g : (s == 1) ? o : p;
  endfunction
  function integer win(input integer g, input integer e);
    win = (g >= e - 1 && g <= e + 1);
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n = n + 1;
    end
    if (pready !== 1'b1) num_errors = num_errors + 1;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // Aligns to a first channel rise, then times the other edges from it
  task measure;
    reg pc, p2;
  begin
    n = 0;
    while (d1 !== 1'b0 && n < 900) begin @(posedge clock); n = n + 1; end
    while (d1 !== 1'b1 && n < 1800) begin @(posedge clock); n = n + 1; end
    if (d1 !== 1'b1) num_errors = num_errors + 1;
    {t2, tc, tf, w1} = 0;
    pc = ck;
    p2 = d2;
    for (i = 1; i <= 400; i = i + 1)
    begin
      @(posedge clock);
      if (d2 === 1'b1 && p2 !== 1'b1 && t2 == 0) t2 = i;
      if (ck === 1'b1 && pc !== 1'b1 && tc == 0) tc = i;
      if (ck !== 1'b1 && pc === 1'b1 && tc != 0 && tf == 0) tf = i;
      if (d1 !== 1'b1 && w1 == 0) w1 = i;
      pc = ck;
      p2 = d2;
    end
  end
  endtask
  task wrap_up;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  initial
  begin
    #400000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  // ==========
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, `TPP_CFG_RST);
    apb(0, 12'h004, 0);
    chk(rd, `TPP_TICK_RST);
    apb(1, 12'h00c, 32'hffff);
    chk(err, 1);
    apb(0, 12'h00c, 0);
    chk(err, 1);
    chk(rd, 0);
    apb(1, 12'h004, 0);
    apb(0, 12'h004, 0);
    chk(rd, 1);
    apb(1, 12'h004, `TPP_TICK_RST);
    $display("register test done");
    for (s = 0; s < 3; s = s + 1)
    begin
      run_above_thresh <= 1'b0;
      trip_after <= $random(seed) & 10'h00f;
      apb(1, 12'h000, {24'h0, s[1:0], s[1:0], s[1:0], s[1:0]});
      repeat (2) @(posedge clock);
      chk(ramp_gain_code, pick(s, `TPP_GAIN_GND, `TPP_GAIN_OPEN, `TPP_GAIN_SUP));
      run_above_thresh <= 1'b1;
      measure;
      chk(t2, pick(s, `TPP_PH_GND_DEG, `TPP_PH_OPEN_DEG, `TPP_PH_SUP_DEG) * P / 360);
      chk(win(tc, pick(s, `TPP_CK_GND_DEG, `TPP_CK_OPEN_DEG, `TPP_CK_SUP_DEG) * P / 360), 1);
      chk(tf - tc, P / 2);
      chk(win(w1, (pick(s, `TPP_BLANK_GND_NS, `TPP_BLANK_OPEN_NS, `TPP_BLANK_SUP_NS) * 100 + 999) / 1000), 1);
      trip_after <= 10'h3ff;
      measure;
      chk(win(w1, P * pick(s, `TPP_DUTY_LIMIT_SELECT_GND_PCT, `TPP_DUTY_LIMIT_SELECT_OPEN_PCT, `TPP_DUTY_LIMIT_SELECT_SUP_PCT) / 100), 1);
      $display("select test %0d done", s);
    end
    measure;
    run_above_thresh <= 1'b0;
    repeat (2) @(posedge clock);
    chk({d1, d2}, 0);
    $display("run test done");
    trip_after <= $random(seed) & 10'h00f;
    apb(1, 12'h000, 32'h155);
    sync_on <= 1'b1;
    run_above_thresh <= 1'b1;
    repeat (1700) @(posedge clock);
    while (sync_in !== 1'b0) @(posedge clock);
    while (sync_in !== 1'b1) @(posedge clock);
    n = 0;
    while (d1 !== 1'b1 && n < 5) begin @(posedge clock); n = n + 1; end
    chk(n >= 1 && n <= 3, 1);
    apb(0, 12'h008, 0);
    chk(rd[3], 1);
    $display("sync test done");
    wrap_up;
  end
endmodule // test_two_phase_peak_current_pwm
